// [common/nand_id_consts.svh]
`ifndef NAND_ID_CONSTS_SVH
`define NAND_ID_CONSTS_SVH

// ==========================================================
// command and address bytes
`define CMD_SIG 8'h90
`define CMD_PARAM 8'hEC
`define CMD_READ 8'h00
`define CMD_STATUS 8'h70
`define CMD_STATUS_ENH 8'h78
`define CMD_RAND_READ 8'h05
`define CMD_RAND_CONF 8'hE0
`define ADDR_ONFI 8'h20
`define ADDR_PARAM 8'h00

// ==========================================================
// stream geometry
`define PAGE_LEN 11'h100
`define SIG_LEN 11'h004
`define ZERO_LEN 11'h000
`define POS_ZERO 11'h000

// ==========================================================
// parameter page layout
`define SIG_B0 8'h4F
`define SIG_B1 8'h4E
`define SIG_B2 8'h46
`define SIG_B3 8'h49
`define OFS_REV 8'h04
`define OFS_FEAT 8'h06
`define OFS_OPT 8'h08
`define OFS_MAKER 8'h20
`define OFS_MODEL 8'h2C
`define OFS_JEDEC 8'h40
`define OFS_DATE 8'h41
`define OFS_RSVD 8'h43
`define REV_VALUE 16'h0002
`define FEAT_MASK 16'h001F
`define OPT_MASK 16'h003F
`define MAKER_LEN 12
`define MODEL_LEN 20

// ==========================================================
// status byte and timing
`define SR_WP 7
`define SR_RDY 6
`define SR_CTRL 5
`define LOAD_NS 1000
`define CLK_MHZ 40

`endif

// [common/nand_id_pkg.sv]
package nand_id_pkg;

	typedef struct packed
	{
		logic ce_n;
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
		logic [7:0] io;
	} nand_bus_t;

	typedef enum logic [3:0]
	{
		ST_IDLE = 4'h0,
		ST_SIG_ADDR = 4'h1,
		ST_SIG_OUT = 4'h2,
		ST_PP_ADDR = 4'h3,
		ST_PP_BUSY = 4'h4,
		ST_PP_OUT = 4'h5,
		ST_STATUS = 4'h6,
		ST_RR_COL0 = 4'h7,
		ST_RR_COL1 = 4'h8,
		ST_RR_CONF = 4'h9
	} id_state_t;

endpackage

// [core/id_fifo.sv]
`timescale 1ns/1ps

module id_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	always_ff @(posedge core_clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst || flush)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end

endmodule // id_fifo

// [core/param_rom.sv]
`timescale 1ns/1ps
`include "nand_id_consts.svh"

module param_rom #(
	parameter logic [15:0] FEATURES = 16'h0000,
	parameter logic [15:0] OPT_CMDS = 16'h0002,
	parameter logic [95:0] MAKER_NAME = "GENERICFLASH",
	parameter logic [159:0] MODEL_NAME = "IDREAD MODEL 0000   ",
	// arbitrary value, not a real maker code
	parameter logic [7:0] JEDEC_ID = 8'h5A,
	parameter logic [15:0] DATE_CODE = 16'h0000
) (
	input wire logic core_clk,
	input wire logic [7:0] addr,
	output logic [7:0] data
);

	logic [15:0] feat;
	logic [15:0] opt;

	assign feat = FEATURES & `FEAT_MASK;
	assign opt = OPT_CMDS & `OPT_MASK;

	// ==========================================================
	// page contents, multi-byte fields low byte first
	always_ff @(posedge core_clk)
	begin
		data <= 8'h00;
		if (addr == 8'h00)
			data <= `SIG_B0;
		else if (addr == 8'h01)
			data <= `SIG_B1;
		else if (addr == 8'h02)
			data <= `SIG_B2;
		else if (addr == 8'h03)
			data <= `SIG_B3;
		else if (addr == `OFS_REV)
			data <= 8'(`REV_VALUE);
		else if (addr == `OFS_REV + 8'h01)
			data <= 8'(`REV_VALUE >> 8);
		else if (addr == `OFS_FEAT)
			data <= feat[7:0];
		else if (addr == `OFS_FEAT + 8'h01)
			data <= feat[15:8];
		else if (addr == `OFS_OPT)
			data <= opt[7:0];
		else if (addr == `OFS_OPT + 8'h01)
			data <= opt[15:8];
		else if (addr >= `OFS_MAKER && addr < `OFS_MODEL)
			data <= MAKER_NAME[8*(`MAKER_LEN - 1 - int'(addr - `OFS_MAKER)) +: 8];
		else if (addr >= `OFS_MODEL && addr < `OFS_JEDEC)
			data <= MODEL_NAME[8*(`MODEL_LEN - 1 - int'(addr - `OFS_MODEL)) +: 8];
		else if (addr == `OFS_JEDEC)
			data <= JEDEC_ID;
		else if (addr == `OFS_DATE)
			data <= DATE_CODE[7:0];
		else if (addr == `OFS_DATE + 8'h01)
			data <= DATE_CODE[15:8];
	end

endmodule // param_rom

// [core/nand_id_read.sv]
`timescale 1ns/1ps
`include "nand_id_consts.svh"

// Operation
// - 90h plus address 20h returns signature
// - signature bytes O N F I; page starts same
// - bytes after fourth signature are undefined
// - signature state holds until next command; 78h leaves it held
// - parameter page repeated at least five times
// - random data read repositions page output
// - status read allowed; 00h resumes output
// - multi-byte parameters least significant first
// - sizes reported in bytes, host converts
// - unused and reserved fields read zero
// - revision field only bit 1 set
// - features field bits 0-4, rest zero
// - optional commands bits 0-5, rest zero
// - maker, model, maker id, date code
module nand_id_read
	import nand_id_pkg::*;
#(
	parameter int COPIES = 5,
	parameter int FIFO_DEPTH = 8,
	parameter logic [15:0] FEATURES = 16'h0000,
	parameter logic [15:0] OPT_CMDS = 16'h0002,
	// arbitrary value, not a real maker code
	parameter logic [7:0] JEDEC_ID = 8'h5A,
	parameter logic [15:0] DATE_CODE = 16'h0000
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire nand_bus_t bus,
	input wire logic wp_n,
	output logic [7:0] io_out,
	output logic io_oe,
	output logic rb_n
);

	localparam int LOAD_CYC = (`LOAD_NS * `CLK_MHZ + 999) / 1000;
	localparam logic [10:0] PP_LIMIT = 11'(COPIES * int'(`PAGE_LEN));

	id_state_t state;
	logic pp_active;
	logic we_n_prev;
	logic re_n_prev;
	logic we_rise;
	logic re_fall;
	logic cmd_strobe;
	logic addr_strobe;
	logic [7:0] col_lo;
	logic [2:0] pos_hi_col;
	logic [15:0] busy_cnt;
	logic start;
	logic [10:0] start_pos;
	logic [10:0] start_limit;
	logic [10:0] pos;
	logic [10:0] limit;
	logic pend;
	logic gen_en;
	logic issue;
	logic [7:0] rom_data;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_pop;
	logic [7:0] fifo_out_data;
	logic out_mode;
	logic [7:0] status_byte;

	// ==========================================================
	// strobe edges
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			we_n_prev <= 1'b1;
			re_n_prev <= 1'b1;
		end
		else
		begin
			we_n_prev <= bus.we_n;
			re_n_prev <= bus.re_n;
		end
	end

	assign we_rise = !bus.ce_n && !we_n_prev && bus.we_n;
	assign re_fall = !bus.ce_n && re_n_prev && !bus.re_n;
	assign cmd_strobe = we_rise && bus.cle && !bus.ale;
	assign addr_strobe = we_rise && bus.ale && !bus.cle;

	// ==========================================================
	// command sequencer
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			state <= ST_IDLE;
			pp_active <= 1'b0;
			col_lo <= 8'h00;
		end
		else if (cmd_strobe)
		begin
			// any new command except 78h leaves signature output
			unique case (bus.io)
				`CMD_SIG:
				begin
					state <= ST_SIG_ADDR;
					pp_active <= 1'b0;
				end
				`CMD_PARAM:
				begin
					state <= ST_PP_ADDR;
					pp_active <= 1'b0;
				end
				`CMD_STATUS:
					state <= ST_STATUS;
				`CMD_READ:
					state <= (state == ST_STATUS && pp_active) ? ST_PP_OUT : ST_IDLE;
				`CMD_RAND_READ:
					state <= (state == ST_PP_OUT) ? ST_RR_COL0 : ST_IDLE;
				`CMD_RAND_CONF:
					state <= (state == ST_RR_CONF) ? ST_PP_OUT : ST_IDLE;
				`CMD_STATUS_ENH:
					state <= state;
				default:
				begin
					state <= ST_IDLE;
					pp_active <= 1'b0;
				end
			endcase
		end
		else if (addr_strobe)
		begin
			unique case (state)
				ST_SIG_ADDR:
					state <= ST_SIG_OUT;
				ST_PP_ADDR:
				begin
					if (bus.io == `ADDR_PARAM)
					begin
						state <= ST_PP_BUSY;
						pp_active <= 1'b1;
					end
					else
						state <= ST_IDLE;
				end
				ST_RR_COL0:
				begin
					col_lo <= bus.io;
					state <= ST_RR_COL1;
				end
				ST_RR_COL1:
					state <= ST_RR_CONF;
				default:
					state <= state;
			endcase
		end
		else if (state == ST_PP_BUSY && busy_cnt == 16'h0001)
			state <= ST_PP_OUT;
	end

	// ==========================================================
	// page load busy time
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			busy_cnt <= 16'h0000;
			rb_n <= 1'b1;
		end
		else if (addr_strobe && state == ST_PP_ADDR && bus.io == `ADDR_PARAM)
		begin
			busy_cnt <= 16'(LOAD_CYC);
			rb_n <= 1'b0;
		end
		else if (busy_cnt != 16'h0000)
		begin
			busy_cnt <= busy_cnt - 16'h0001;
			rb_n <= (busy_cnt == 16'h0001);
		end
	end

	// ==========================================================
	// stream restart requests
	always_comb
	begin
		start = 1'b0;
		start_pos = `POS_ZERO;
		start_limit = `ZERO_LEN;
		if (addr_strobe && state == ST_SIG_ADDR)
		begin
			start = 1'b1;
			// only the compliance signature is defined here
			start_limit = (bus.io == `ADDR_ONFI) ? `SIG_LEN : `ZERO_LEN;
		end
		else if (cmd_strobe && (bus.io == `CMD_SIG || bus.io == `CMD_PARAM))
			start = 1'b1;
		// load end restarts the stream even while status is shown
		else if (busy_cnt == 16'h0001)
		begin
			start = 1'b1;
			start_limit = PP_LIMIT;
		end
		else if (cmd_strobe && bus.io == `CMD_RAND_CONF && state == ST_RR_CONF)
		begin
			start = 1'b1;
			start_pos = {pos_hi_col, col_lo};
			start_limit = PP_LIMIT;
		end
		else if (cmd_strobe && bus.io == `CMD_READ && !(state == ST_STATUS && pp_active))
			start = 1'b1;
	end

	// ==========================================================
	// random read column, high bits
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			pos_hi_col <= 3'h0;
		else if (addr_strobe && state == ST_RR_COL1)
			pos_hi_col <= bus.io[2:0];
	end

	// ==========================================================
	// byte generator feeding the fifo
	assign gen_en = (state == ST_SIG_OUT) || (state == ST_PP_OUT) || (state == ST_STATUS);
	assign issue = gen_en && !pend && fifo_in_ready && (pos < limit) && !start;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			pos <= `POS_ZERO;
			limit <= `ZERO_LEN;
			pend <= 1'b0;
		end
		else if (start)
		begin
			pos <= start_pos;
			limit <= start_limit;
			pend <= 1'b0;
		end
		else if (issue)
		begin
			pos <= pos + 11'h001;
			pend <= 1'b1;
		end
		else
			pend <= 1'b0;
	end

	// page offset wraps so each copy repeats the structure
	param_rom #(
		.FEATURES(FEATURES),
		.OPT_CMDS(OPT_CMDS),
		.JEDEC_ID(JEDEC_ID),
		.DATE_CODE(DATE_CODE)
	) u_rom (
		.core_clk(core_clk),
		.addr(pos[7:0]),
		.data(rom_data)
	);

	id_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.flush(start),
		.in_valid(pend),
		.in_ready(fifo_in_ready),
		.in_data(rom_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	// ==========================================================
	// output register
	assign out_mode = (state == ST_SIG_OUT) || (state == ST_PP_OUT);
	assign fifo_pop = re_fall && out_mode;

	always_comb
	begin
		status_byte = 8'h00;
		status_byte[`SR_WP] = wp_n;
		status_byte[`SR_RDY] = rb_n;
		status_byte[`SR_CTRL] = rb_n;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			io_out <= 8'h00;
		else if (state == ST_STATUS)
			io_out <= status_byte;
		else if (fifo_pop)
			// byte units on the 8-bit lane; past the stream reads zero
			io_out <= fifo_out_valid ? fifo_out_data : 8'h00;
	end

	assign io_oe = !bus.ce_n && !bus.re_n;

endmodule // nand_id_read

// [sim/nand_host_model.sv]
`timescale 1ns/1ps

module nand_host_model
	import nand_id_pkg::*;
(
	input wire logic core_clk,
	input wire logic [7:0] io_out,
	input wire logic io_oe,
	output nand_bus_t bus
);
	initial
	begin
		bus = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, io: 8'hA5};
	end

	// =====
	// command or address write cycle
	task automatic wr(input logic cmd, input logic [7:0] v);
		@(negedge core_clk);
		bus.ce_n = 1'b0;
		bus.cle = cmd;
		bus.ale = ~cmd;
		bus.io = v;
		bus.we_n = 1'b0;
		@(negedge core_clk);
		bus.we_n = 1'b1;
		@(negedge core_clk);
		bus.cle = 1'b0;
		bus.ale = 1'b0;
		bus.io = ~v;
	endtask

	// read cycle, host io lines driven inverted
	task automatic rd(output logic [7:0] v, output logic oe);
		@(negedge core_clk);
		bus.ce_n = 1'b0;
		bus.re_n = 1'b0;
		bus.io = ~bus.io;
		repeat (2) @(negedge core_clk);
		v = io_out;
		oe = io_oe;
		bus.re_n = 1'b1;
		repeat (2) @(negedge core_clk);
	endtask

	task automatic idle(input int n);
		@(negedge core_clk);
		bus.ce_n = 1'b1;
		repeat (n) @(negedge core_clk);
	endtask
endmodule // nand_host_model

// [sim/nand_id_read_sva.sv]
`timescale 1ns/1ps

module nand_id_read_sva
	import nand_id_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire nand_bus_t bus,
	input wire logic wp_n,
	input wire logic [7:0] io_out,
	input wire logic io_oe,
	input wire logic rb_n
);
	int busy_cnt;

	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	always_ff @(posedge core_clk)
	begin
		if (sys_rst || rb_n)
			busy_cnt <= 0;
		else
			busy_cnt <= busy_cnt + 1;
	end

	// =====
	// checks
	AST_OE_ON: assert property (!bus.ce_n && !bus.re_n |-> io_oe)
		else $error("output enable missing during read");
	AST_OE_OFF: assert property (bus.ce_n || bus.re_n |-> !io_oe)
		else $error("output enable outside read");
	AST_BUSY_LEN: assert property ($rose(rb_n) |-> busy_cnt == 40)
		else $error("busy length not 40 cycles");
	AST_BUSY_CAP: assert property (!rb_n |-> busy_cnt < 40)
		else $error("busy longer than 40 cycles");
	AST_BUSY_MIN: assert property ($fell(rb_n) |-> !rb_n [*8])
		else $error("busy pulse too short");
	AST_BUSY_CAUSE: assert property ($fell(rb_n) |-> $past(bus.ale) && !$past(bus.cle)
		&& !$past(bus.ce_n) && $past(bus.io) == 8'h00)
		else $error("busy without page address write");
	AST_LOAD_HOLD: assert property ($fell(rb_n) |=> $stable(io_out))
		else $error("output moved at load start");
	AST_QUIET: assert property (bus.ce_n && $past(bus.ce_n) && $past(bus.ce_n, 2)
		&& $past(bus.ce_n, 3) && $stable(rb_n) && $past(rb_n) == $past(rb_n, 2)
		&& $past(wp_n) == $past(wp_n, 2) |-> $stable(io_out))
		else $error("output changed while deselected");
endmodule // nand_id_read_sva

bind nand_id_read nand_id_read_sva chk (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus),
	.wp_n(wp_n), .io_out(io_out), .io_oe(io_oe), .rb_n(rb_n));

// [sim/tb_nand_id_read.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) \
	checks_done++; \
	if ((g) !== (e)) \
	begin \
		failures++; \
		$display("[FAIL] %s expected %h seen %h", nm, e, g); \
	end

module tb_nand_id_read
	import nand_id_pkg::*;
;
	localparam logic [15:0] FEAT = 16'hFF13;
	localparam logic [15:0] OPTC = 16'hFFE5;
	localparam logic [15:0] DATE = 16'h1A2B;
	localparam logic [95:0] MAKER = "GENERICFLASH";
	localparam logic [159:0] MODEL = "IDREAD MODEL 0000   ";
	// arbitrary value
	localparam logic [7:0] MAKER_ID = 8'h3C;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic wp_n = 1'b1;
	nand_bus_t bus;
	logic [7:0] io_out;
	logic io_oe;
	logic rb_n;
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [7:0] v;

	always #12.5 core_clk = ~core_clk;

	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			finish_test();
		end
	end

	nand_host_model host (.core_clk(core_clk), .io_out(io_out), .io_oe(io_oe), .bus(bus));

	nand_id_read #(.FEATURES(FEAT), .OPT_CMDS(OPTC), .JEDEC_ID(MAKER_ID), .DATE_CODE(DATE)) DUT (
		.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus), .wp_n(wp_n),
		.io_out(io_out), .io_oe(io_oe), .rb_n(rb_n));

	// =====
	// expectations and helpers
	function automatic logic [7:0] exp_byte(input int i);
		int p;
		logic [31:0] sig;
		logic [15:0] feat_exp;
		logic [15:0] opt_exp;
		sig = 32'h49464E4F;
		// reserved feature and command bits read zero
		feat_exp = FEAT & 16'h001F;
		opt_exp = OPTC & 16'h003F;
		p = i % 256;
		if (p < 4) return sig[8*p +: 8];
		if (p == 4) return 8'h02;
		if (p == 6 || p == 7) return feat_exp[8*(p-6) +: 8];
		if (p == 8 || p == 9) return opt_exp[8*(p-8) +: 8];
		if (p >= 32 && p < 44) return MAKER[8*(43-p) +: 8];
		if (p >= 44 && p < 64) return MODEL[8*(63-p) +: 8];
		if (p == 64) return MAKER_ID;
		if (p == 65 || p == 66) return DATE[8*(p-65) +: 8];
		return 8'h00;
	endfunction

	task automatic get(input logic [7:0] e);
		logic oe;
		host.rd(v, oe);
		`CHK("io_oe", 1'b1, oe)
		`CHK("io_out", e, v)
	endtask

	task automatic status(input logic rdy);
		logic oe;
		wp_n = 1'($urandom);
		host.wr(1'b1, 8'h70);
		host.rd(v, oe);
		`CHK("status", {wp_n, rdy, rdy, 5'h00}, v)
	endtask

	task automatic wait_rb(output int n);
		n = 0;
		// count from the falling edge that ended the address write
		for (int k = 0; k < 100 && (n == 0 || !rb_n); k++)
		begin
			if (!rb_n)
				n++;
			@(negedge core_clk);
		end
		repeat (4) @(negedge core_clk);
	endtask

	task automatic finish_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// =====
	// main sequence
	initial
	begin
		int n;
		int col;
		n = $urandom(46879);
		repeat (20) @(negedge core_clk);
		sys_rst = 1'b0;
		`CHK("rb_n", 1'b1, rb_n)
		host.wr(1'b1, 8'h90);
		host.wr(1'b0, 8'h20);
		host.idle(8);
		for (int i = 0; i < 4; i++)
			get(exp_byte(i));
		n = $urandom_range(255, 33);
		host.wr(1'b1, 8'h90);
		host.wr(1'b0, n[7:0]);
		host.idle(8);
		get(8'h00);
		host.wr(1'b1, 8'hEC);
		host.wr(1'b0, 8'h00);
		wait_rb(n);
		`CHK("busy_len", 40, n)
		for (int i = 0; i < 5 * 256; i++)
			get(exp_byte(i));
		get(8'h00);
		host.wr(1'b1, 8'hEC);
		host.wr(1'b0, 8'h00);
		status(1'b0);
		wait_rb(n);
		status(1'b1);
		host.wr(1'b1, 8'h00);
		host.idle(8);
		for (int i = 0; i < 12; i++)
		begin
			if (i == 6)
			begin
				status(1'b1);
				host.wr(1'b1, 8'h00);
				host.idle(8);
			end
			get(exp_byte(i));
		end
		for (int j = 0; j < 4; j++)
		begin
			col = (j == 0) ? 1279 : $urandom_range(1278, 0);
			host.wr(1'b1, 8'h05);
			host.wr(1'b0, col[7:0]);
			host.wr(1'b0, {5'h00, col[10:8]});
			host.wr(1'b1, 8'hE0);
			host.idle(8);
			get(exp_byte(col));
		end
		finish_test();
	end
endmodule // tb_nand_id_read
